// File: include/mbld_pkg.sv
// Shared constants, opcodes and types of the branch and load decoder
`default_nettype none
package mbld_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PC_W       = 14;  // Instruction pointer width
  localparam int unsigned OFS_W      = 8;   // In-page offset width
  localparam int unsigned PAGE_W     = 6;   // Page number width
  localparam int unsigned PAGE_COUNT = 64;  // ROM pages
  localparam int unsigned PAGE_WORDS = 256; // Words per page
  localparam int unsigned ZP_W       = 6;   // Zero-page target width
  localparam int unsigned WORD_W     = 10;  // Instruction word width
  localparam int unsigned NIB_W      = 4;   // Nibble register width
  localparam int unsigned WREG_W     = 2;   // W register width
  localparam int unsigned RAM_A_W    = 10;  // RAM address width
  localparam int unsigned GROUP_COUNT = 10; // Instruction groups
  localparam int unsigned INSTR_COUNT = 101; // Instructions in the set

  // ----------------------------------------------------------------
  // Field positions of a fetched ROM data word
  // ----------------------------------------------------------------
  localparam int unsigned DATA_AB_BIT   = 8; // Write accumulator and B
  localparam int unsigned DATA_PORT_BIT = 9; // Write both port registers

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [13:0] PC_RST  = 14'h0000;
  localparam logic [3:0]  NIB_RST = 4'h0;
  localparam logic [1:0]  W_RST   = 2'h0;

  // ----------------------------------------------------------------
  // Opcodes: six-bit prefixes carrying a four-bit field
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_ACC_LOAD_IMM      = 6'h23;
  localparam logic [5:0] OP_SECOND_LOAD_IMM   = 6'h20;
  localparam logic [5:0] OP_MEM_STORE_IMM_INC = 6'h29;
  localparam logic [5:0] OP_XREG_LOAD_IMM     = 6'h22;
  localparam logic [5:0] OP_YREG_LOAD_IMM     = 6'h21;
  localparam logic [5:0] OP_LONG_JUMP         = 6'h14;
  localparam logic [5:0] OP_LONG_BRANCH_ALT   = 6'h15;
  localparam logic [5:0] OP_LONG_CALL         = 6'h16;
  localparam logic [5:0] OP_TABLE_JUMP        = 6'h0b;
  localparam logic [5:0] OP_TABLE_FETCH       = 6'h1b;
  // Shorter prefixes
  localparam logic [7:0] OP_WREG_LOAD_IMM     = 8'h3c; // Two-bit field
  localparam logic [1:0] OP_IN_PAGE_JUMP      = 2'h3;  // Eight-bit field
  localparam logic [3:0] OP_ZERO_PAGE_CALL    = 4'h7;  // Six-bit field
  // Whole words
  localparam logic [9:0] OP_ACC_FROM_WREG     = 10'h100;
  localparam logic [9:0] OP_WREG_FROM_ACC     = 10'h110;
  localparam logic [9:0] OP_ACC_FROM_B        = 10'h048;
  localparam logic [9:0] OP_B_FROM_ACC        = 10'h0c8;
  localparam logic [9:0] OP_ACC_FROM_Y        = 10'h0af;
  localparam logic [9:0] OP_X_FROM_ACC        = 10'h0e8;
  localparam logic [9:0] OP_Y_FROM_ACC        = 10'h0d8;
  localparam logic [9:0] OP_INC_Y             = 10'h05c;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Source of the next instruction pointer
  typedef enum logic [2:0] {
    MBLD_PC_SEQ,
    MBLD_PC_HOLD,
    MBLD_PC_LONG,
    MBLD_PC_PAGE,
    MBLD_PC_ZERO,
    MBLD_PC_TABLE
  } mbld_pc_mode_e;

  // Decoder sequencing states
  typedef enum logic [1:0] {
    MBLD_ST_EXEC,
    MBLD_ST_LONG_TGT,
    MBLD_ST_XFER_W,
    MBLD_ST_TABLE_DATA
  } mbld_state_e;

endpackage
`default_nettype wire

// File: hdl/mbld_nib_reg.sv
// Loadable register with synchronous reset and clock enable
`timescale 1ns/10ps
`default_nettype none
module mbld_nib_reg #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             en,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Clears at reset, loads when enabled and asked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else if (en && load) begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// File: hdl/mbld_pc_next.sv
// Next instruction pointer and table address generation
`timescale 1ns/10ps
`default_nettype none
module mbld_pc_next (
  input  wire logic                   [13:0] pc,
  input  wire mbld_pkg::mbld_pc_mode_e       mode,
  input  wire logic                   [9:0]  word,
  input  wire logic                   [3:0]  hi_nib,
  input  wire logic                   [3:0]  acc,
  input  wire logic                   [3:0]  breg,
  output logic                        [13:0] pc_d,
  output logic                        [13:0] table_addr
);

  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------
  logic [13:0] pc_inc; // Sequential successor

  // Already-advanced pointer is the base for in-page jumps
  assign pc_inc = pc + 14'h0001;

  // Table target from field, B and accumulator
  assign table_addr = {2'h0, hi_nib, breg, acc};

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  always_comb begin
    unique case (mode)
      mbld_pkg::MBLD_PC_SEQ:   pc_d = pc_inc;
      mbld_pkg::MBLD_PC_HOLD:  pc_d = pc;
      // Whole pointer replaced by fourteen bits
      mbld_pkg::MBLD_PC_LONG:  pc_d = {hi_nib, word};
      // Page bits kept, offset replaced; page of successor used
      mbld_pkg::MBLD_PC_PAGE:  pc_d = {pc_inc[13:8], word[7:0]};
      // Upper eight bits cleared
      mbld_pkg::MBLD_PC_ZERO:  pc_d = {8'h00, word[5:0]};
      mbld_pkg::MBLD_PC_TABLE: pc_d = table_addr;
      default:                 pc_d = pc_inc;
    endcase
  end

endmodule
`default_nettype wire

// File: hdl/mbld_decoder.sv
// Branch, table fetch and load instruction decoder of a 4-bit core
//
// Overview of operation
// - Long jumps load all fourteen pointer bits.
// - ROM is 64 pages of 256 words.
// - In-page jump replaces only low eight bits.
// - Jump at page end lands in next page.
// - Zero-page call loads six bits, clears rest.
// - Table jump uses field, accumulator and B.
// - Fetched bit 8 writes accumulator and B.
// - Fetched bit 9 writes both port registers.
// - Both bits write all four together.
// - Table fetch never branches the pointer.
// - Set of 101 instructions in ten groups.
// - Prefix 100011 loads accumulator immediate, one cycle.
// - Prefix 100000 loads B immediate, one cycle.
// - Prefix 101001 stores immediate, increments Y, status.
// - W immediate load takes two bits.
// - X immediate load takes four bits.
// - Y immediate load takes four bits.
// - Accumulator/W transfers take two words, two cycles.
// - RAM address is W, X, Y concatenated.
`timescale 1ns/10ps
`default_nettype none
module mbld_decoder (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        CLK_EN,
  input  wire logic [9:0]  ROM_DATA,
  output logic      [13:0] ROM_ADDR,
  output logic      [13:0] INSTR_POINTER,
  output logic      [3:0]  ACC,
  output logic      [3:0]  BREG,
  output logic      [1:0]  WREG,
  output logic      [3:0]  XREG,
  output logic      [3:0]  YREG,
  output logic             NONZERO_STATUS,
  output logic      [3:0]  PORT_OUT_REG_ONE,
  output logic      [3:0]  PORT_OUT_REG_TWO,
  output logic      [9:0]  RAM_ADDR,
  output logic      [3:0]  RAM_WDATA,
  output logic             RAM_WE,
  output logic             UNDECODED
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mbld_pkg::mbld_state_e   state_q;      // Sequencing state
  mbld_pkg::mbld_state_e   state_d;      // Next sequencing state
  mbld_pkg::mbld_pc_mode_e pc_mode;      // Pointer source this cycle
  logic [13:0]             pc_q;         // Instruction pointer
  logic [13:0]             pc_d;         // Next instruction pointer
  logic [13:0]             table_addr;   // Table data address
  logic [13:0]             rom_addr_q;   // Address shown to ROM
  logic [13:0]             rom_addr_d;   // Next address shown to ROM
  logic [3:0]              hi_nib;       // Upper field to pointer logic
  logic [3:0]              long_hi_q;    // Held upper long-target bits
  logic [3:0]              long_hi_d;    // Next held upper bits
  logic                    w_to_acc_q;   // Pending transfer direction
  logic                    w_to_acc_d;   // Next transfer direction
  logic [9:0]              word;         // Word under execution
  logic [3:0]              y_inc;        // Y plus one
  // Register load controls
  logic                    a_ld;
  logic [3:0]              a_d;
  logic                    b_ld;
  logic [3:0]              b_d;
  logic                    w_ld;
  logic [1:0]              w_d;
  logic                    x_ld;
  logic [3:0]              x_d;
  logic                    y_ld;
  logic [3:0]              y_d;
  logic                    nz_ld;        // Update nonzero status
  logic                    port_ld;      // Update port registers
  logic                    ram_we_d;     // Issue a RAM write
  logic [3:0]              ram_wdata_d;  // RAM write nibble
  logic                    undecoded_d;  // Word not handled here

  assign word  = ROM_DATA;
  assign y_inc = YREG + 4'h1;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Accumulator
  mbld_nib_reg #(.WIDTH(mbld_pkg::NIB_W)) u_acc (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .en    (CLK_EN),
    .load  (a_ld),
    .d     (a_d),
    .q     (ACC)
  );

  // B register
  mbld_nib_reg #(.WIDTH(mbld_pkg::NIB_W)) u_breg (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .en    (CLK_EN),
    .load  (b_ld),
    .d     (b_d),
    .q     (BREG)
  );

  // W register, two bits
  mbld_nib_reg #(.WIDTH(mbld_pkg::WREG_W)) u_wreg (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .en    (CLK_EN),
    .load  (w_ld),
    .d     (w_d),
    .q     (WREG)
  );

  // X register
  mbld_nib_reg #(.WIDTH(mbld_pkg::NIB_W)) u_xreg (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .en    (CLK_EN),
    .load  (x_ld),
    .d     (x_d),
    .q     (XREG)
  );

  // Y register
  mbld_nib_reg #(.WIDTH(mbld_pkg::NIB_W)) u_yreg (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .en    (CLK_EN),
    .load  (y_ld),
    .d     (y_d),
    .q     (YREG)
  );

  // ----------------------------------------------------------------
  // Pointer arithmetic
  // ----------------------------------------------------------------
  mbld_pc_next u_pc_next (
    .pc         (pc_q),
    .mode       (pc_mode),
    .word       (word),
    .hi_nib     (hi_nib),
    .acc        (ACC),
    .breg       (BREG),
    .pc_d       (pc_d),
    .table_addr (table_addr)
  );

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // One word per cycle; long forms hold a second state
  always_comb begin
    state_d     = state_q;
    pc_mode     = mbld_pkg::MBLD_PC_SEQ;
    hi_nib      = word[3:0];
    long_hi_d   = long_hi_q;
    w_to_acc_d  = w_to_acc_q;
    a_ld        = 1'b0;
    a_d         = ACC;
    b_ld        = 1'b0;
    b_d         = BREG;
    w_ld        = 1'b0;
    w_d         = WREG;
    x_ld        = 1'b0;
    x_d         = XREG;
    y_ld        = 1'b0;
    y_d         = YREG;
    nz_ld       = 1'b0;
    port_ld     = 1'b0;
    ram_we_d    = 1'b0;
    ram_wdata_d = RAM_WDATA;
    undecoded_d = 1'b0;
    unique case (state_q)
      mbld_pkg::MBLD_ST_EXEC: begin
        if (word[9:4] == mbld_pkg::OP_ACC_LOAD_IMM) begin
          // Immediate to accumulator, single cycle
          a_ld = 1'b1;
          a_d  = word[3:0];
        end else if (word[9:4] == mbld_pkg::OP_SECOND_LOAD_IMM) begin
          // Immediate to B, single cycle
          b_ld = 1'b1;
          b_d  = word[3:0];
        end else if (word[9:4] == mbld_pkg::OP_MEM_STORE_IMM_INC) begin
          // Store at current address, then bump Y
          ram_we_d    = 1'b1;
          ram_wdata_d = word[3:0];
          y_ld        = 1'b1;
          y_d         = y_inc;
          nz_ld       = 1'b1;
        end else if (word[9:2] == mbld_pkg::OP_WREG_LOAD_IMM) begin
          // Two-bit immediate to W
          w_ld = 1'b1;
          w_d  = word[1:0];
        end else if (word[9:4] == mbld_pkg::OP_XREG_LOAD_IMM) begin
          x_ld = 1'b1;
          x_d  = word[3:0];
        end else if (word[9:4] == mbld_pkg::OP_YREG_LOAD_IMM) begin
          y_ld = 1'b1;
          y_d  = word[3:0];
        end else if (word == mbld_pkg::OP_ACC_FROM_WREG ||
                     word == mbld_pkg::OP_WREG_FROM_ACC) begin
          // First of two words; operand word follows
          w_to_acc_d = (word == mbld_pkg::OP_ACC_FROM_WREG);
          state_d    = mbld_pkg::MBLD_ST_XFER_W;
        end else if (word[9:4] == mbld_pkg::OP_LONG_JUMP ||
                     word[9:4] == mbld_pkg::OP_LONG_BRANCH_ALT ||
                     word[9:4] == mbld_pkg::OP_LONG_CALL) begin
          // Keep upper target bits, low ten come next
          long_hi_d = word[3:0];
          state_d   = mbld_pkg::MBLD_ST_LONG_TGT;
        end else if (word[9:8] == mbld_pkg::OP_IN_PAGE_JUMP) begin
          pc_mode = mbld_pkg::MBLD_PC_PAGE;
        end else if (word[9:6] == mbld_pkg::OP_ZERO_PAGE_CALL) begin
          pc_mode = mbld_pkg::MBLD_PC_ZERO;
        end else if (word[9:4] == mbld_pkg::OP_TABLE_JUMP) begin
          pc_mode = mbld_pkg::MBLD_PC_TABLE;
        end else if (word[9:4] == mbld_pkg::OP_TABLE_FETCH) begin
          // Advance past this word; data read next cycle
          state_d = mbld_pkg::MBLD_ST_TABLE_DATA;
        end else if (word == mbld_pkg::OP_ACC_FROM_B) begin
          a_ld = 1'b1;
          a_d  = BREG;
        end else if (word == mbld_pkg::OP_B_FROM_ACC) begin
          b_ld = 1'b1;
          b_d  = ACC;
        end else if (word == mbld_pkg::OP_ACC_FROM_Y) begin
          a_ld = 1'b1;
          a_d  = YREG;
        end else if (word == mbld_pkg::OP_X_FROM_ACC) begin
          x_ld = 1'b1;
          x_d  = ACC;
        end else if (word == mbld_pkg::OP_Y_FROM_ACC) begin
          y_ld = 1'b1;
          y_d  = ACC;
        end else if (word == mbld_pkg::OP_INC_Y) begin
          y_ld  = 1'b1;
          y_d   = y_inc;
          nz_ld = 1'b1;
        end else begin
          // Other groups of the set execute elsewhere
          undecoded_d = 1'b1;
        end
      end
      mbld_pkg::MBLD_ST_LONG_TGT: begin
        // Second word supplies the low ten target bits
        pc_mode = mbld_pkg::MBLD_PC_LONG;
        hi_nib  = long_hi_q;
        state_d = mbld_pkg::MBLD_ST_EXEC;
      end
      mbld_pkg::MBLD_ST_XFER_W: begin
        // Operand word consumed, transfer completes
        if (w_to_acc_q) begin
          a_ld = 1'b1;
          a_d  = {2'h0, WREG};
        end else begin
          w_ld = 1'b1;
          w_d  = ACC[1:0];
        end
        state_d = mbld_pkg::MBLD_ST_EXEC;
      end
      mbld_pkg::MBLD_ST_TABLE_DATA: begin
        // Data word at table address; pointer stays put
        pc_mode = mbld_pkg::MBLD_PC_HOLD;
        if (word[mbld_pkg::DATA_AB_BIT]) begin
          a_ld = 1'b1;
          a_d  = word[3:0];
          b_ld = 1'b1;
          b_d  = word[7:4];
        end
        port_ld = word[mbld_pkg::DATA_PORT_BIT];
        state_d = mbld_pkg::MBLD_ST_EXEC;
      end
    endcase
  end

  // Table address shown during the fetch cycle, else the pointer
  assign rom_addr_d = (state_d == mbld_pkg::MBLD_ST_TABLE_DATA) ?
                      table_addr : pc_d;

  // ----------------------------------------------------------------
  // Sequencing state and pointer
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_q    <= mbld_pkg::MBLD_ST_EXEC;
      pc_q       <= mbld_pkg::PC_RST;
      rom_addr_q <= mbld_pkg::PC_RST;
      long_hi_q  <= mbld_pkg::NIB_RST;
      w_to_acc_q <= 1'b0;
    end else if (CLK_EN) begin
      state_q    <= state_d;
      pc_q       <= pc_d;
      rom_addr_q <= rom_addr_d;
      long_hi_q  <= long_hi_d;
      w_to_acc_q <= w_to_acc_d;
    end
  end

  // ----------------------------------------------------------------
  // Status flag
  // ----------------------------------------------------------------
  // Nonzero status tracks the incremented Y
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      NONZERO_STATUS <= 1'b0;
    end else if (CLK_EN && nz_ld) begin
      NONZERO_STATUS <= (y_inc != 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // Port output registers
  // ----------------------------------------------------------------
  // Low data nibble to port one, high to port two
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PORT_OUT_REG_ONE <= mbld_pkg::NIB_RST;
      PORT_OUT_REG_TWO <= mbld_pkg::NIB_RST;
    end else if (CLK_EN && port_ld) begin
      PORT_OUT_REG_ONE <= word[3:0];
      PORT_OUT_REG_TWO <= word[7:4];
    end
  end

  // ----------------------------------------------------------------
  // RAM write port
  // ----------------------------------------------------------------
  // Address taken before Y moves; write lasts one cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      RAM_ADDR  <= 10'h000;
      RAM_WDATA <= mbld_pkg::NIB_RST;
      RAM_WE    <= 1'b0;
    end else if (CLK_EN) begin
      RAM_ADDR  <= {WREG, XREG, YREG};
      RAM_WDATA <= ram_wdata_d;
      RAM_WE    <= ram_we_d;
    end
  end

  // ----------------------------------------------------------------
  // Undecoded indication
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      UNDECODED <= 1'b0;
    end else if (CLK_EN) begin
      UNDECODED <= undecoded_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ROM_ADDR         = rom_addr_q;
  assign INSTR_POINTER    = pc_q;

endmodule
`default_nettype wire

// File: dv/mbld_decoder_props.sv
// Concurrent checks of the branch and load decoder
`timescale 1ns/10ps
`default_nettype none
module mbld_chk (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        CLK_EN,
  input wire logic [9:0]  ROM_DATA,
  input wire logic [13:0] ROM_ADDR,
  input wire logic [13:0] INSTR_POINTER,
  input wire logic [3:0]  ACC,
  input wire logic [3:0]  BREG,
  input wire logic [3:0]  YREG,
  input wire logic        NONZERO_STATUS,
  input wire logic [3:0]  PORT_OUT_REG_ONE,
  input wire logic [3:0]  PORT_OUT_REG_TWO,
  input wire logic [3:0]  RAM_WDATA,
  input wire logic        RAM_WE
);
  // ------------------------------------------------
  // Execute tracking
  // ------------------------------------------------
  logic        opnd_q; // Next word is an operand
  logic        ex;     // Word at the pointer executes
  logic        lng;    // Long jump prefix
  logic [13:0] nxt;    // Pointer after advance
  assign lng = ROM_DATA[9:4] inside {mbld_pkg::OP_LONG_JUMP, mbld_pkg::OP_LONG_BRANCH_ALT,
                                     mbld_pkg::OP_LONG_CALL};
  assign ex  = CLK_EN && !opnd_q && ROM_ADDR == INSTR_POINTER;
  assign nxt = INSTR_POINTER + 14'h0001;
  // Marks the operand word of two-word forms
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      opnd_q <= 1'b0;
    end else if (CLK_EN) begin
      opnd_q <= ex && (lng || ROM_DATA == mbld_pkg::OP_ACC_FROM_WREG
                           || ROM_DATA == mbld_pkg::OP_WREG_FROM_ACC);
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence long_first;
    ex && lng;
  endsequence
  sequence fetch_first;
    ex && ROM_DATA[9:4] == mbld_pkg::OP_TABLE_FETCH;
  endsequence
  AST_LONG_JUMP: assert property (long_first ##1 1'b1 |=>
    INSTR_POINTER == {$past(ROM_DATA[3:0], 2), $past(ROM_DATA)}) else $error("Long target");
  AST_PAGE_JUMP: assert property (ex && ROM_DATA[9:8] == 2'h3 |=>
    INSTR_POINTER == {$past(nxt[13:8]), $past(ROM_DATA[7:0])}) else $error("Page target");
  AST_ZERO_CALL: assert property (ex && ROM_DATA[9:6] == 4'h7 |=>
    INSTR_POINTER == {8'h00, $past(ROM_DATA[5:0])}) else $error("Zero page target");
  AST_FETCH_ADDR: assert property (fetch_first |=>
    ROM_ADDR == {2'h0, $past(ROM_DATA[3:0]), $past(BREG), $past(ACC)}
    ##1 INSTR_POINTER == $past(nxt, 2) && ROM_ADDR == INSTR_POINTER) else $error("Fetch");
  AST_FETCH_AB: assert property (fetch_first ##1 ROM_DATA[8] |=>
    {BREG, ACC} == $past(ROM_DATA[7:0])) else $error("Fetch to A and B");
  AST_FETCH_PORT: assert property (fetch_first ##1 ROM_DATA[9] |=>
    {PORT_OUT_REG_TWO, PORT_OUT_REG_ONE} == $past(ROM_DATA[7:0])) else $error("Fetch to ports");
  AST_ACC_IMM: assert property (ex && ROM_DATA[9:4] == mbld_pkg::OP_ACC_LOAD_IMM |=>
    ACC == $past(ROM_DATA[3:0])) else $error("Accumulator load");
  AST_STORE_INC: assert property (
    ex && ROM_DATA[9:4] == mbld_pkg::OP_MEM_STORE_IMM_INC |=>
    RAM_WE && RAM_WDATA == $past(ROM_DATA[3:0]) && YREG == $past(YREG) + 4'h1
    && NONZERO_STATUS == (YREG != 4'h0)) else $error("Store and increment");
endmodule
bind mbld_decoder mbld_chk u_mbld_chk (.SYS_CLK, .RST_N, .CLK_EN, .ROM_DATA, .ROM_ADDR,
  .INSTR_POINTER, .ACC, .BREG, .YREG, .NONZERO_STATUS, .PORT_OUT_REG_ONE, .PORT_OUT_REG_TWO,
  .RAM_WDATA, .RAM_WE);
`default_nettype wire

// File: dv/test_mbld_decoder.sv
// Directed bench of the branch and load decoder
`timescale 1ns/10ps
`default_nettype none
module test_mbld_decoder;
  logic        clk = 1'b0;                       // System clock
  logic        rst_n = 1'b0;                     // Synchronous reset
  logic [9:0]  rom_data = 10'h000;               // Word shown to the core
  logic [13:0] rom_addr, ip;                     // ROM address and pointer
  logic [3:0]  acc, breg, xreg, yreg, p1, p2, wd; // Core registers and write data
  logic [1:0]  wreg;                             // W register
  logic [9:0]  raddr;                            // RAM address
  logic        nz, we, und;                      // Status, write strobe, undecoded
  logic        clk_en = 1'b1;                    // Clock enable
  logic [9:0]  rom [16384] = '{default: 10'h000}; // Program store
  int          error_cnt = 0;                    // Mismatches
  int          num_checks = 0;                   // Comparisons
  mbld_decoder u_mbld_decoder (.SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .ROM_DATA(rom_data),
    .ROM_ADDR(rom_addr), .INSTR_POINTER(ip), .ACC(acc), .BREG(breg), .WREG(wreg), .XREG(xreg),
    .YREG(yreg), .NONZERO_STATUS(nz), .PORT_OUT_REG_ONE(p1), .PORT_OUT_REG_TWO(p2),
    .RAM_ADDR(raddr), .RAM_WDATA(wd), .RAM_WE(we), .UNDECODED(und));
  initial begin
    forever #25 clk = ~clk;
  end
  // ROM answers off the sampling edge
  always @(negedge clk) begin
    rom_data <= rom[rom_addr];
  end
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic [13:0] a, input logic [9:0] w []);
    foreach (w[i]) rom[a + 14'(i)] = w[i];
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic go;
    rst_n = 1'b0;
    step(16);
    rst_n = 1'b1;
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Immediate loads, then two stores with Y increment
  task automatic sc_imm;
    put(14'h0, '{10'h235, 10'h20a, 10'h22c, 10'h21f, 10'h0f2, 10'h297, 10'h21e, 10'h297});
    go();
    step(1);
    chk(acc, 4'h5, "acc");
    step(1);
    chk(breg, 4'ha, "breg");
    step(1);
    chk(xreg, 4'hc, "xreg");
    step(1);
    chk(yreg, 4'hf, "yreg");
    step(1);
    chk(wreg, 2'h2, "wreg");
    step(1);
    chk({we, wd}, 5'h17, "store");
    chk(raddr, 10'h2cf, "raddr");
    chk({yreg, nz}, 5'h00, "wrap");
    step(1);
    chk(we, 1'b0, "we");
    step(1);
    chk({yreg, nz}, 5'h1f, "inc");
    chk(raddr, 10'h2ce, "raddr");
  endtask
  // Every long form replaces the whole pointer
  task automatic sc_long;
    logic [5:0] ops [3] = '{mbld_pkg::OP_LONG_JUMP, mbld_pkg::OP_LONG_BRANCH_ALT,
                            mbld_pkg::OP_LONG_CALL};
    foreach (ops[k]) begin
      put(14'h0, '{{ops[k], 4'h3}, 10'h2a5});
      go();
      step(2);
      chk(ip, 14'h0ea5, "ip");
      step(1);
      chk({und, ip}, 18'h04ea6, "undecoded");
    end
  endtask
  // In-page jump at a page end, inside a page, then zero page
  task automatic sc_page;
    put(14'h0, '{10'h140, 10'h0ff});
    put(14'h00ff, '{10'h312});
    put(14'h0112, '{10'h340});
    put(14'h0140, '{10'h1ed});
    go();
    step(3);
    chk(ip, 14'h0112, "ip");
    step(1);
    chk(ip, 14'h0140, "ip");
    step(1);
    chk(ip, 14'h002d, "ip");
    clk_en = 1'b0;
    step(3);
    chk(ip, 14'h002d, "frozen");
    clk_en = 1'b1;
  endtask
  // Table jump, then fetches to ports, to A and B, and to both
  task automatic sc_table;
    put(14'h0, '{10'h233, 10'h205, 10'h0b2});
    put(14'h0253, '{10'h1b1, 10'h1b2, 10'h1b0});
    put(14'h0153, '{10'h2c4});
    put(14'h00b1, '{10'h3e7});
    go();
    step(3);
    chk(ip, 14'h0253, "ip");
    step(1);
    chk(rom_addr, 14'h0153, "addr");
    step(1);
    chk({p2, p1, breg, acc}, 16'hc453, "port");
    chk(ip, 14'h0254, "ip");
    step(2);
    chk({p2, p1, breg, acc}, 16'hc4b1, "ab");
    step(2);
    chk({p2, p1, breg, acc}, 16'he7e7, "both");
    chk(ip, 14'h0256, "ip");
  endtask
  // Accumulator and W transfers with their operand words
  task automatic sc_xfer;
    put(14'h0, '{10'h236, 10'h110, 10'h000, 10'h231, 10'h100, 10'h000, 10'h0d8,
                 10'h05c, 10'h0e8, 10'h0af, 10'h0c8, 10'h23f, 10'h048});
    go();
    step(3);
    chk({ip, wreg}, 16'h000e, "w");
    step(3);
    chk({ip, acc}, 18'h00062, "a");
    step(3);
    chk({yreg, nz, xreg}, 9'h072, "moves");
    step(2);
    chk({breg, acc}, 8'h33, "ab moves");
    step(2);
    chk(acc, 4'h3, "a from b");
  endtask
  // Cuts a hang short
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    sc_imm();
    sc_long();
    sc_page();
    sc_table();
    sc_xfer();
    report_and_stop();
  end
endmodule
`default_nettype wire
